// [hw/sbr_pkg.sv]
/*
 * Constants for the interrupt cause and system configuration registers:
 * frame layout, field positions, reset values and cycle counts.
 * Assumes a 25 MHz system clock and a 16-bit serial frame.
 */
package sbr_pkg;

   // ==========================================================
   // Frame layout
   localparam int          FRAME_BITS = 16;
   localparam int          ADDR_HI    = 15;
   localparam int          ADDR_LO    = 14;
   localparam int          RRS_BIT    = 13;
   localparam int          RO_BIT     = 12;
   localparam logic [1:0]  ADDR_IRQ   = 2'h1;
   localparam logic [1:0]  ADDR_CFG   = 2'h2;
   localparam logic [4:0]  CNT_GOOD   = 5'h10;
   localparam logic [4:0]  CNT_MAX    = 5'h1f;
   localparam logic [4:0]  CNT_SEL    = 5'h03;

   // ==========================================================
   // Interrupt cause bit positions
   localparam int C_WDOG_TIMEOUT = 11;
   localparam int C_OVERTEMP     = 10;
   localparam int C_GROUND_SHIFT = 9;
   localparam int C_FRAME_COUNT  = 8;
   localparam int C_RESERVED     = 7;
   localparam int C_SUPPLY_FAIL  = 6;
   localparam int C_CAN_FAULT    = 5;
   localparam int C_LIN_FAULT    = 4;
   localparam int C_LOCAL_WAKE   = 3;
   localparam int C_WDOG_RESTART = 2;
   localparam int C_CAN_WAKE     = 1;
   localparam int C_LIN_WAKE     = 0;

   // ==========================================================
   // System configuration bit positions
   localparam int G_GROUND_THR   = 9;
   localparam int G_RST_STRETCH  = 8;
   localparam int G_REG3_HI      = 7;
   localparam int G_REG3_LO      = 6;
   localparam int G_RESERVED     = 5;
   localparam int G_REG1_CURMON  = 4;
   localparam int G_WAKE_EN      = 3;
   localparam int G_WAKE_SAMPLE  = 2;
   localparam int G_INH_EN       = 1;
   localparam int G_INH_LEVEL    = 0;

   // ==========================================================
   // Reset values and write masks
   localparam logic [11:0] CAUSE_RESET = 12'h000;
   localparam logic [11:0] IEN_RESET   = 12'h000;
   localparam logic [9:0]  CFG_RESET   = 10'h000;
   localparam logic [11:0] IEN_WMASK   = 12'hf7f;
   localparam logic [9:0]  CFG_WMASK   = 10'h3df;

   // ==========================================================
   // Times and cycle counts
   localparam int CLK_MHZ         = 25;
   localparam int IRQ_OUT_N_RELEASE_NS = 1000;
   localparam int RST_SHORT_NS    = 2000;
   localparam int RST_LONG_NS     = 20000;
   localparam int WAKE_SAMPLE_NS  = 4000;
   localparam int IRQ_OUT_N_RELEASE_CYC =
      (IRQ_OUT_N_RELEASE_NS * CLK_MHZ + 999) / 1000;
   localparam int RST_SHORT_CYC = (RST_SHORT_NS * CLK_MHZ + 999) / 1000;
   localparam int RST_LONG_CYC  = (RST_LONG_NS * CLK_MHZ + 999) / 1000;
   localparam int WAKE_SAMPLE_CYC = (WAKE_SAMPLE_NS * CLK_MHZ) / 1000;
   localparam int RST_CNT_W  = $clog2(RST_LONG_CYC + 1);
   localparam int REL_CNT_W  = $clog2(IRQ_OUT_N_RELEASE_CYC + 1);
   localparam int WAKE_CNT_W = $clog2(WAKE_SAMPLE_CYC + 1);

endpackage : sbr_pkg

// [hw/sbr_regs.sv]
/*
 * Interrupt cause and system configuration registers of a system basis
 * chip, reached by a 16-bit serial frame from the host controller.
 * Assumes the host holds the select low at least four system clocks
 * before the first serial clock edge and high at least four system
 * clocks between frames; the serial clock stands still outside frames.
 */
//
// Function
// - Code 01 reaches the cause register; bit 12 makes it read only.
// - Code 01 with bit 12 clear returns causes and loads the enables.
// - Bit 11 set when a standby watchdog overflow gave an interrupt.
// - Bit 10 set on any change of the temperature warning flag.
// - Bit 9 set on any change of the ground shift flag.
// - A frame without exactly 16 clocks is ignored and sets bit 8.
// - Bit 6 set when any regulator ok flag clears.
// - Bit 5 on any CAN fault change, bit 4 on any LIN fault change.
// - Bit 3 set on a falling edge of the local wake input.
// - Bit 2 set when a watchdog restart while off gave an interrupt.
// - Bit 1 on CAN wake interrupt, bit 0 on LIN wake interrupt.
// - Address code 10 selects the system configuration register.
// - Bit 13 returns general feedback 0, else the configuration.
// - Bit 12 set only reads; clear also stores configuration bits.
// - Configuration bit 9 picks the widened ground shift threshold.
// - Bit 8 picks long reset stretch; set on restart or fail-safe.
// - Bits 7:6 set regulator three: long cyclic, short cyclic, on, off.
// - Bit 4: regulator one current rise in standby resets or rearms.
// - Bit 3 clear disables the wake input, freezes its level flag and stops new wake events.
// - Bit 2 selects cyclic wake sampling, else continuous sampling.
// - Bit 1 clear floats inhibit output; set drives level of bit 0.
// - Causes clear on read and reset, new ones kept, output released.
`timescale 1ns/10ps
module sbr_regs #(
   parameter int CAN_W = 4,
   parameter int LIN_W = 2
) (
   input  wire logic             clk_sys,
   input  wire logic             sys_rst,
   input  wire logic             spi_sck,
   input  wire logic             spi_csn,
   input  wire logic             spi_mosi,
   output      logic             spi_miso,
   input  wire logic             wdog_overflow_standby,
   input  wire logic             wdog_restart_irq,
   input  wire logic             can_wake_irq,
   input  wire logic             lin_wake_irq,
   input  wire logic             temp_warning_flag,
   input  wire logic             ground_shift_flag,
   input  wire logic             reg1_ok_flag,
   input  wire logic             reg2_ok_flag,
   input  wire logic             reg3_ok_flag,
   input  wire logic [CAN_W-1:0] can_fail_status,
   input  wire logic [LIN_W-1:0] lin_fail_status,
   input  wire logic             wake_pin,
   input  wire logic             enter_restart_failsafe,
   input  wire logic             standby_mode,
   input  wire logic             wdog_disabled,
   input  wire logic             reg1_current_rise,
   input  wire logic             ext_reset_n,
   input  wire logic [15:0]      gp_feedback0,
   output      logic             irq_out_n,
   output      logic [11:0]      irq_enable,
   output      logic             ground_threshold_select,
   output      logic             reset_stretch_select,
   output      logic [1:0]       reg3_mode,
   output      logic             reg1_current_monitor_select,
   output      logic             wake_sampling_select,
   output      logic             wake_event_flag,
   output      logic             wake_level_flag,
   output      logic             reset_out_n,
   output      logic             wdog_reactivate,
   output      logic             current_reset_req,
   output      logic             inhibit_limp_output,
   output      logic             inhibit_limp_oe
);
   import sbr_pkg::*;

   initial begin
      if (CAN_W < 1 || CAN_W > 16 || LIN_W < 1 || LIN_W > 16) begin
         $error("Fault status widths must lie between 1 and 16.");
      end
   end

   // ==========================================================
   // System clock domain state
   typedef struct packed {
      logic                  csn_s1;
      logic                  csn_s2;
      logic                  csn_d;
      logic                  wake_s1;
      logic                  wake_s2;
      logic                  wake_d;
      logic                  rst_s1;
      logic                  rst_s2;
      logic                  link_clr;
      logic [11:0]           cause;
      logic [11:0]           ien;
      logic [9:0]            cfg;
      logic [11:0]           snap_cause;
      logic [9:0]            snap_cfg;
      logic [12:0]           snap_gp;
      logic                  temp_d;
      logic                  gs_d;
      logic [CAN_W-1:0]      can_d;
      logic [LIN_W-1:0]      lin_d;
      logic [2:0]            ok_d;
      logic                  irq_n;
      logic [REL_CNT_W-1:0]  rel_cnt;
      logic [WAKE_CNT_W-1:0] wake_cnt;
      logic                  wake_level;
      logic                  wake_event;
      logic [RST_CNT_W-1:0]  rst_cnt;
      logic                  rst_out_n;
      logic                  wdog_react;
      logic                  cur_reset;
      logic                  inh_out;
      logic                  inh_oe;
   } sbr_sys_t;

   // ==========================================================
   // Link clock domain state
   typedef struct packed {
      logic [4:0] count;
      logic [2:0] sel;
      logic       miso;
   } sbr_link_t;

   sbr_sys_t  r;
   sbr_sys_t  next_r;
   sbr_link_t l;
   sbr_link_t next_l;
   logic [15:0] shift;

   // ==========================================================
   // Link side: the clear comes from the system side only while the
   // select is idle, so the count and shifted word stay still while the
   // system side reads them after the frame.
   function automatic logic [12:0] sbr_tx_word(
      input logic [2:0]  sel,
      input logic [11:0] cause,
      input logic [9:0]  cfg,
      input logic [12:0] gp
   );
      logic [12:0] w;
      w = 13'h0000;
      if (sel[2:1] == ADDR_IRQ) begin
         w = {1'b0, cause};
      end else if (sel[2:1] == ADDR_CFG) begin
         w = sel[0] ? gp : {3'h0, cfg};
      end
      return w;
   endfunction : sbr_tx_word

   always_comb begin
      logic [2:0]  sel_now;
      logic [12:0] word;
      sel_now = (l.count == CNT_SEL) ? shift[2:0] : l.sel;
      word    = sbr_tx_word(sel_now, r.snap_cause, r.snap_cfg, r.snap_gp);
      next_l  = l;
      if (l.count != CNT_MAX) begin
         next_l.count = l.count + 5'h01;
      end
      if (l.count == CNT_SEL) begin
         next_l.sel = shift[2:0];
      end
      if (l.count >= CNT_SEL && l.count < CNT_GOOD) begin
         next_l.miso = word[4'(FRAME_BITS - 1) - 4'(l.count)];
      end else begin
         next_l.miso = 1'b0;
      end
   end

   always_ff @(posedge spi_sck or posedge r.link_clr) begin
      if (r.link_clr) begin
         l <= '0;
      end else begin
         l <= next_l;
      end
   end

   // The host samples on the falling edge, and so does the device.
   always_ff @(negedge spi_sck) begin
      shift <= {shift[14:0], spi_mosi};
   end

   // ==========================================================
   // System side
   always_comb begin
      logic        frame_end;
      logic        frame_ok;
      logic [1:0]  addr;
      logic [11:0] set;
      logic [11:0] clr;
      logic        wake_fall;
      logic        sample;
      logic        rst_low;
      frame_end = 1'b0;
      frame_ok  = 1'b0;
      addr      = 2'h0;
      set       = '0;
      clr       = '0;
      wake_fall = 1'b0;
      sample    = 1'b1;
      rst_low   = 1'b0;
      next_r = r;
      next_r.csn_s1  = spi_csn;
      next_r.csn_s2  = r.csn_s1;
      next_r.csn_d   = r.csn_s2;
      next_r.wake_s1 = wake_pin;
      next_r.wake_s2 = r.wake_s1;
      next_r.rst_s1  = ext_reset_n;
      next_r.rst_s2  = r.rst_s1;
      next_r.temp_d  = temp_warning_flag;
      next_r.gs_d    = ground_shift_flag;
      next_r.can_d   = can_fail_status;
      next_r.lin_d   = lin_fail_status;
      next_r.ok_d    = {reg3_ok_flag, reg2_ok_flag, reg1_ok_flag};

      frame_end = r.csn_s2 && !r.csn_d;
      frame_ok  = frame_end && (l.count == CNT_GOOD);
      addr      = shift[ADDR_HI:ADDR_LO];
      next_r.link_clr = r.csn_s2 && (r.link_clr || r.csn_d);

      // Snapshots only move while idle, so the link reads stable words.
      if (r.csn_s2 && r.link_clr) begin
         next_r.snap_cause = r.cause;
         next_r.snap_cfg   = r.cfg;
         next_r.snap_gp    = gp_feedback0[12:0];
      end

      // Wake input, sampled continuously or once per sample period.
      sample = 1'b1;
      if (r.cfg[G_WAKE_SAMPLE]) begin
         sample = (r.wake_cnt == '0);
      end
      if (r.wake_cnt == '0) begin
         next_r.wake_cnt = WAKE_CNT_W'(WAKE_SAMPLE_CYC - 1);
      end else begin
         next_r.wake_cnt = r.wake_cnt - 1'b1;
      end
      wake_fall = 1'b0;
      if (r.cfg[G_WAKE_EN] && sample) begin
         next_r.wake_d     = r.wake_s2;
         next_r.wake_level = r.wake_s2;
         wake_fall         = r.wake_d && !r.wake_s2;
      end

      set = '0;
      set[C_WDOG_TIMEOUT] = wdog_overflow_standby
                            && r.ien[C_WDOG_TIMEOUT];
      set[C_OVERTEMP]     = temp_warning_flag != r.temp_d;
      set[C_GROUND_SHIFT] = ground_shift_flag != r.gs_d;
      set[C_FRAME_COUNT]  = frame_end && !frame_ok;
      set[C_SUPPLY_FAIL]  = |(r.ok_d & ~{reg3_ok_flag,
                              reg2_ok_flag, reg1_ok_flag});
      set[C_CAN_FAULT]    = can_fail_status != r.can_d;
      set[C_LIN_FAULT]    = lin_fail_status != r.lin_d;
      set[C_LOCAL_WAKE]   = wake_fall;
      set[C_WDOG_RESTART] = wdog_restart_irq;
      set[C_CAN_WAKE]     = can_wake_irq;
      set[C_LIN_WAKE]     = lin_wake_irq;

      // A read clears only what the host actually saw; an event in the
      // same cycle survives because the set is applied last.
      clr = '0;
      if (frame_ok && addr == ADDR_IRQ) begin
         clr = r.snap_cause;
         next_r.wake_event = 1'b0;
         if (!shift[RO_BIT]) begin
            next_r.ien = shift[11:0] & IEN_WMASK;
         end
      end
      next_r.cause = (r.cause & ~clr) | set;
      if (wdog_overflow_standby) begin
         next_r.ien[C_WDOG_TIMEOUT] = 1'b0;
      end
      if (wake_fall) begin
         next_r.wake_event = 1'b1;
      end

      if (frame_ok && addr == ADDR_CFG && !shift[RO_BIT]) begin
         next_r.cfg = shift[9:0] & CFG_WMASK;
      end
      if (enter_restart_failsafe) begin
         next_r.cfg[G_RST_STRETCH] = 1'b1;
      end

      // Interrupt output with a guaranteed release after each read.
      if (|clr || (frame_ok && addr == ADDR_IRQ)) begin
         next_r.rel_cnt = REL_CNT_W'(IRQ_OUT_N_RELEASE_CYC);
      end else if (r.rel_cnt != '0) begin
         next_r.rel_cnt = r.rel_cnt - 1'b1;
      end
      next_r.irq_n = !((|(r.cause & r.ien))
                       && (r.rel_cnt == '0));

      // Reset stretching: a short external spike is held for the
      // selected length.
      rst_low = !r.rst_s2;
      if (rst_low) begin
         next_r.rst_cnt = r.cfg[G_RST_STRETCH] ?
                          RST_CNT_W'(RST_LONG_CYC) :
                          RST_CNT_W'(RST_SHORT_CYC);
      end else if (r.rst_cnt != '0) begin
         next_r.rst_cnt = r.rst_cnt - 1'b1;
      end
      next_r.rst_out_n = !(rst_low || r.rst_cnt != '0);

      // Regulator one current monitor in standby.
      next_r.wdog_react = 1'b0;
      next_r.cur_reset  = 1'b0;
      if (reg1_current_rise && standby_mode) begin
         if (r.cfg[G_REG1_CURMON] && wdog_disabled) begin
            next_r.cur_reset = 1'b1;
         end else begin
            next_r.wdog_react = 1'b1;
         end
      end

      next_r.inh_oe  = r.cfg[G_INH_EN];
      next_r.inh_out = r.cfg[G_INH_EN] && r.cfg[G_INH_LEVEL];
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         r            <= '0;
         r.csn_s1     <= 1'b1;
         r.csn_s2     <= 1'b1;
         r.csn_d      <= 1'b1;
         r.link_clr   <= 1'b1;
         r.cause      <= CAUSE_RESET;
         r.ien        <= IEN_RESET;
         r.cfg        <= CFG_RESET;
         r.irq_n      <= 1'b1;
         r.rst_s1     <= 1'b1;
         r.rst_s2     <= 1'b1;
         r.rst_out_n  <= 1'b1;
         r.wake_s1    <= 1'b1;
         r.wake_s2    <= 1'b1;
         r.wake_d     <= 1'b1;
         r.wake_level <= 1'b1;
         // Detectors start at the present levels to avoid a false cause.
         r.temp_d     <= temp_warning_flag;
         r.gs_d       <= ground_shift_flag;
         r.can_d      <= can_fail_status;
         r.lin_d      <= lin_fail_status;
         r.ok_d       <= {reg3_ok_flag, reg2_ok_flag, reg1_ok_flag};
      end else begin
         r <= next_r;
      end
   end

   // ==========================================================
   // Outputs, each straight from a flip-flop.
   assign spi_miso                    = l.miso;
   assign irq_out_n                   = r.irq_n;
   assign irq_enable                  = r.ien;
   assign ground_threshold_select     = r.cfg[G_GROUND_THR];
   assign reset_stretch_select        = r.cfg[G_RST_STRETCH];
   assign reg3_mode = r.cfg[G_REG3_HI:G_REG3_LO];
   assign reg1_current_monitor_select = r.cfg[G_REG1_CURMON];
   assign wake_sampling_select        = r.cfg[G_WAKE_SAMPLE];
   assign wake_event_flag             = r.wake_event;
   assign wake_level_flag             = r.wake_level;
   assign reset_out_n                 = r.rst_out_n;
   assign wdog_reactivate             = r.wdog_react;
   assign current_reset_req           = r.cur_reset;
   assign inhibit_limp_output         = r.inh_out;
   assign inhibit_limp_oe             = r.inh_oe;

endmodule : sbr_regs

// [verif/sbr_regs_assertions.sv]
/* Checker for the cause and configuration register block.
   Assumes every watched port belongs to the clk_sys domain. */
`timescale 1ns/10ps
module sbr_regs_assertions (
   input wire logic        clk_sys,
   input wire logic        sys_rst,
   input wire logic        spi_csn,
   input wire logic        ext_reset_n,
   input wire logic        enter_restart_failsafe,
   input wire logic        reg1_current_rise,
   input wire logic        standby_mode,
   input wire logic        wdog_disabled,
   input wire logic        wdog_overflow_standby,
   input wire logic        irq_out_n,
   input wire logic [11:0] irq_enable,
   input wire logic        reset_stretch_select,
   input wire logic [1:0]  reg3_mode,
   input wire logic        reg1_current_monitor_select,
   input wire logic        reset_out_n,
   input wire logic        wdog_reactivate,
   input wire logic        current_reset_req,
   input wire logic        inhibit_limp_output,
   input wire logic        inhibit_limp_oe
);
   // ==========================================================
   // Properties
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   rst_clear_a: assert property (disable iff (1'b0)
      sys_rst |=> irq_out_n && irq_enable == 12'h000)
      else $error("interrupt state not cleared by reset");
   irq_gate_a: assert property (
      irq_enable == 12'h000 |=> irq_out_n)
      else $error("interrupt asserted with no enable set");
   cfg_stable_a: assert property (
      !spi_csn [*5] |-> $stable(reg3_mode) && $stable(irq_enable[10:0]))
      else $error("settings changed in mid frame");
   wdog_clear_a: assert property (
      wdog_overflow_standby |=> !irq_enable[11])
      else $error("overflow left its enable set");
   stretch_set_a: assert property (
      enter_restart_failsafe |=> reset_stretch_select)
      else $error("restart entry did not pick long stretch");
   rst_hold_a: assert property (
      !ext_reset_n [*4] |-> !reset_out_n)
      else $error("reset output not following reset input");
   stretch_short_a: assert property (
      $rose(ext_reset_n) && !reset_stretch_select
      |-> ##40 !reset_out_n ##[1:20] reset_out_n)
      else $error("short reset stretch length wrong");
   curmon_reset_a: assert property (
      reg1_current_rise && standby_mode && wdog_disabled &&
      reg1_current_monitor_select |=> current_reset_req)
      else $error("current rise did not request reset");
   curmon_rearm_a: assert property (
      reg1_current_rise && standby_mode &&
      !(wdog_disabled && reg1_current_monitor_select)
      |=> wdog_reactivate && !current_reset_req)
      else $error("current rise did not only rearm watchdog");
   inh_float_a: assert property (
      !inhibit_limp_oe |-> !inhibit_limp_output)
      else $error("inhibit output driven while floating");
   cover property (reg1_current_rise && reg1_current_monitor_select);
   cover property ($rose(ext_reset_n) && reset_stretch_select);
   cover property ($fell(irq_out_n));
endmodule : sbr_regs_assertions
bind sbr_regs sbr_regs_assertions chk (.clk_sys, .sys_rst, .spi_csn,
   .ext_reset_n, .enter_restart_failsafe, .reg1_current_rise, .standby_mode,
   .wdog_disabled, .wdog_overflow_standby, .irq_out_n, .irq_enable,
   .reset_stretch_select, .reg3_mode, .reg1_current_monitor_select,
   .reset_out_n, .wdog_reactivate, .current_reset_req,
   .inhibit_limp_output, .inhibit_limp_oe);

// [verif/sbr_host.sv]
/* Host controller model: master of the 16-bit serial frame.
   Assumes the caller spaces frames; the clock idles low. */
`timescale 1ns/10ps
module sbr_host (
   output logic      spi_sck,
   output logic      spi_csn,
   output logic      spi_mosi,
   input  wire logic spi_miso
);
   initial begin
      spi_sck  = 1'b0;
      spi_csn  = 1'b1;
      spi_mosi = 1'b1;
   end
   // ==========================================================
   // Frame transfer
   // Data changes on the rising clock and is read back on the falling one.
   task automatic xfer(input logic [15:0] w, input int n,
                       output logic [15:0] r);
      r = 16'h0000;
      if (w[15:14] == 2'h1) w[7] = 1'b0;
      spi_csn = 1'b0;
      #200;
      for (int i = 0; i < n; i++) begin
         spi_sck  = 1'b1;
         spi_mosi = w[15 - (i % 16)];
         #24;
         spi_sck = 1'b0;
         r = {r[14:0], spi_miso};
         #24;
      end
      spi_csn  = 1'b1;
      spi_mosi = ~spi_mosi;
      #400;
   endtask : xfer
endmodule : sbr_host

// [verif/sbr_regs_tb.sv]
/* Self-checking bench for the cause and configuration registers.
   Assumes the host model and the bound checker are compiled alongside. */
`timescale 1ns/10ps
module sbr_regs_tb;
   import sbr_pkg::*;
   logic        clk_sys, sys_rst, spi_sck, spi_csn, spi_mosi, spi_miso;
   logic        wdog_overflow_standby, wdog_restart_irq, can_wake_irq;
   logic        lin_wake_irq, temp_warning_flag, ground_shift_flag;
   logic        reg1_ok_flag, reg2_ok_flag, reg3_ok_flag, wake_pin;
   logic        enter_restart_failsafe, standby_mode, wdog_disabled;
   logic        reg1_current_rise, ext_reset_n, irq_out_n;
   logic        ground_threshold_select, reset_stretch_select;
   logic        reg1_current_monitor_select, wake_sampling_select;
   logic        wake_event_flag, wake_level_flag, reset_out_n;
   logic        wdog_reactivate, current_reset_req;
   logic        inhibit_limp_output, inhibit_limp_oe;
   logic [3:0]  can_fail_status;
   logic [1:0]  lin_fail_status, reg3_mode;
   logic [11:0] irq_enable, e;
   logic [15:0] gp_feedback0, rd;
   logic [31:0] seed = 32'h51;
   int          error_cnt = 0;
   int          n_compared = 0;
   // Cause bit raised by each event of the table below.
   localparam int BIT_OF [12] = '{11, 10, 9, 8, 6, 5,
      4, 3, 2, 1, 0, 8};

   sbr_regs dut (.*);
   sbr_host host (.spi_sck, .spi_csn, .spi_mosi, .spi_miso);

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // ==========================================================
   // Helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function automatic logic [15:0] exp_cause(input int k);
      return 16'h0001 << BIT_OF[k];
   endfunction : exp_cause
   function automatic logic [15:0] exp_cfg(input logic [11:0] d);
      return {8'h00, d[9:6], d[4], d[2], d[1], d[1] & d[0]};
   endfunction : exp_cfg
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : cyc
   task automatic fr(input logic [15:0] w, input int n = 16);
      host.xfer(w, n, rd);
      cyc(1);
   endtask : fr
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   function automatic logic [15:0] cfg_now();
      return {8'h00, ground_threshold_select, reset_stretch_select,
         reg3_mode, reg1_current_monitor_select, wake_sampling_select,
         inhibit_limp_oe, inhibit_limp_output};
   endfunction : cfg_now
   task automatic fire(input int k);
      cyc(1);
      case (k)
         0: wdog_overflow_standby = 1'b1;
         1: temp_warning_flag = ~temp_warning_flag;
         2: ground_shift_flag = ~ground_shift_flag;
         3: fr({ADDR_CFG, 14'h03ff}, 15);
         4: reg1_ok_flag = 1'b0;
         5: can_fail_status ^= 4'h5;
         6: lin_fail_status ^= 2'h1;
         7: wake_pin = 1'b0;
         8: wdog_restart_irq = 1'b1;
         9: can_wake_irq = 1'b1;
         10: lin_wake_irq = 1'b1;
         default: fr({ADDR_CFG, 14'h03ff}, 17);
      endcase
      cyc(1);
      {wdog_overflow_standby, wdog_restart_irq, can_wake_irq} = 3'h0;
      lin_wake_irq = 1'b0;
      reg1_ok_flag = 1'b1;
      cyc(20);
      wake_pin = 1'b1;
   endtask : fire
   task automatic conclude();
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : conclude

   // ==========================================================
   // Tests
   initial begin
      {sys_rst, reg1_ok_flag, reg2_ok_flag, reg3_ok_flag} = 4'hf;
      {wake_pin, ext_reset_n, standby_mode, wdog_disabled} = 4'hf;
      {wdog_overflow_standby, wdog_restart_irq, can_wake_irq} = 3'h0;
      {lin_wake_irq, temp_warning_flag, ground_shift_flag} = 3'h0;
      {enter_restart_failsafe, reg1_current_rise} = 2'h0;
      {can_fail_status, lin_fail_status, gp_feedback0} = 22'h0;
      cyc(10);
      sys_rst = 1'b0;
      cyc(3);
      chk({irq_enable, 3'h0, irq_out_n}, 16'h0001);
      chk(cfg_now(), 16'h0000);
      for (int i = 0; i < 8; i++) begin
         e = 12'(rnd());
         e[7:6] = i[1:0];
         gp_feedback0 = 16'(rnd());
         fr({ADDR_CFG, 2'b00, e});
         fr({ADDR_CFG, 2'b01, ~e});
         chk(rd, {4'h0, e & {2'b00, CFG_WMASK}});
         chk(cfg_now(), exp_cfg(e));
         fr({ADDR_CFG, 2'b11, 12'h000});
         chk(rd, {3'h0, gp_feedback0[12:0]});
         wdog_disabled = i[2];
         reg1_current_rise = 1'b1;
         cyc(1);
         reg1_current_rise = 1'b0;
      end
      fr({2'h3, 14'h03ff});
      chk(rd, 16'h0000);
      chk(cfg_now(), exp_cfg(e));
      $display("test configuration done");
      e = 12'(rnd());
      fr({ADDR_IRQ, 2'b00, e});
      chk({4'h0, irq_enable}, {4'h0, e & IEN_WMASK});
      fr({ADDR_CFG, 14'h0008});
      for (int k = 0; k < 12; k++) begin
         fr({ADDR_IRQ, 14'h0f7f});
         fire(k);
         chk({15'h0, wake_event_flag}, {15'h0, k == 7});
         chk({15'h0, irq_out_n}, {15'h0, k == 0});
         fr({ADDR_IRQ, 14'h1000});
         chk(rd, exp_cause(k));
         chk({4'h0, irq_enable}, k == 0 ? 16'h077f : 16'h0f7f);
         chk(cfg_now(), 16'h0000);
         cyc(30);
         chk({15'h0, irq_out_n}, 16'h0001);
         fr({ADDR_IRQ, 14'h1000});
         chk(rd, 16'h0000);
      end
      fork
         fr({ADDR_IRQ, 14'h1000});
         #320 temp_warning_flag = ~temp_warning_flag;
      join
      chk(rd, 16'h0000);
      chk({15'h0, irq_out_n}, 16'h0001);
      cyc(25);
      chk({15'h0, irq_out_n}, 16'h0000);
      fr({ADDR_IRQ, 14'h1000});
      chk(rd, 16'h0001 << C_OVERTEMP);
      fr({ADDR_CFG, 14'h0000});
      wake_pin = 1'b0;
      cyc(20);
      chk({15'h0, wake_level_flag}, 16'h0001);
      wake_pin = 1'b1;
      temp_warning_flag = ~temp_warning_flag;
      cyc(5);
      sys_rst = 1'b1;
      cyc(2);
      sys_rst = 1'b0;
      cyc(3);
      fr({ADDR_IRQ, 14'h1000});
      chk(rd, 16'h0000);
      $display("test causes done");
      for (int j = 0; j < 2; j++) begin
         ext_reset_n = 1'b0;
         cyc(10);
         ext_reset_n = 1'b1;
         cyc(j == 0 ? 30 : 400);
         chk({15'h0, reset_out_n}, 16'h0000);
         cyc(j == 0 ? 40 : 120);
         chk({15'h0, reset_out_n}, 16'h0001);
         enter_restart_failsafe = 1'b1;
         cyc(1);
         enter_restart_failsafe = 1'b0;
         cyc(2);
         chk({15'h0, reset_stretch_select}, 16'h0001);
      end
      $display("test reset stretch done");
      conclude();
   end

   initial begin
      #2000000;
      error_cnt++;
      $display("[FAIL] %0t ns: watchdog expired", $time);
      conclude();
   end
endmodule : sbr_regs_tb
